// [core/matrix_trap_and_stream_len.sv]
// Operation
// - matrix, mode and sysreg instructions are trappable
// - table instructions trappable by table enables
// - level-1 control traps user/kernel to kernel/hypervisor
// - level-2 control traps up to hypervisor, hypervisor
// - level-3 control traps any level to monitor
// - table enables trap per level to matching target
// - matrix traps report class 0x1d
// - class 0x1d maps to trace trap type
// - stream length derived from level length requests
// - array load/store/zero use stream length always
// - in stream mode vector length equals stream
// - any subset of sizes may be implemented
// - request in 16-byte units, floor at minimum
// - top level request capped at maximum size
// - lower level capped by more privileged level
// - unsupported request rounds down to supported size
// - request field bits [8:0], read returns bytes
// - growth keeps common bits, new bits zero/old
// - length may change inside stream mode
// - raise then restore keeps original contents
// - disabled table access traps with code 4
// - sysreg checks ordered, code 0 each
`default_nettype none
module matrix_trap_and_stream_len #(
  parameter logic [matrix_trap_pkg::NUM_SIZES-1:0] SUPPORTED_SIZES = matrix_trap_pkg::SUPPORTED_DEFAULT,
  parameter bit                                    GROW_ZERO_FILL  = 1'b0
) (
  input  wire logic                                  mclk,
  input  wire logic                                  rst,
  input  wire logic                                  clk_en,
  input  wire logic [1:0]                            cur_level,
  input  wire logic                                  hyp_present,
  input  wire logic                                  kernel_route_to_hyp,
  input  wire logic [1:0]                            level1_matrix_access_enable,
  input  wire logic                                  level2_matrix_access_enable,
  input  wire logic                                  level2_matrix_trap_bit,
  input  wire logic                                  matrix_enable_level3,
  input  wire logic [2:0]                            lookup_table_enable,
  input  wire logic [matrix_trap_pkg::LEN_W-1:0]     stream_length_control_l1,
  input  wire logic [matrix_trap_pkg::LEN_W-1:0]     stream_length_control_l2,
  input  wire logic [matrix_trap_pkg::LEN_W-1:0]     stream_length_control_l3,
  input  wire logic                                  stream_mode_bit,
  input  wire logic                                  array_storage_enable_bit,
  input  wire logic [matrix_trap_pkg::BYTES_W-1:0]   nonstream_vector_bytes,
  input  wire logic                                  instr_valid,
  input  wire logic [2:0]                            instr_kind,
  input  wire logic                                  instr_uses_vector_regs,
  input  wire logic                                  instr_uses_array,
  output logic                                       trap_valid,
  output logic [1:0]                                 trap_target_level,
  output logic [matrix_trap_pkg::EC_W-1:0]           exception_class_field,
  output logic [matrix_trap_pkg::ISS_W-1:0]          trap_syndrome,
  output logic [1:0]                                 trace_exception_type,
  output logic                                       instr_accept,
  output logic [matrix_trap_pkg::BYTES_W-1:0]        read_len_bytes,
  output logic [matrix_trap_pkg::BYTES_W-1:0]        array_access_bytes,
  output logic [matrix_trap_pkg::BYTES_W-1:0]        effective_stream_length,
  output logic [matrix_trap_pkg::BYTES_W-1:0]        effective_vector_length,
  output logic                                       stream_len_grew,
  output logic                                       grow_fill_zero
);

  // decoded views of the input buses
  matrix_trap_pkg::level_e      lvl;            // current privilege level
  matrix_trap_pkg::instr_kind_e kind;           // current instruction class
  assign lvl  = matrix_trap_pkg::level_e'(cur_level);
  assign kind = matrix_trap_pkg::instr_kind_e'(instr_kind);

  // length resolver connection
  len_if lif ();
  logic [matrix_trap_pkg::KIDX_W-1:0] k_cur;    // resolved index at current level

  // drive the resolver from the three requests, bits [8:0] of each control
  assign lif.req1        = stream_length_control_l1;
  assign lif.req2        = stream_length_control_l2;
  assign lif.req3        = stream_length_control_l3;
  assign lif.hyp_present = hyp_present;
  assign lif.supported   = SUPPORTED_SIZES;

  stream_len_resolver u_resolver (
    .lif (lif.resolver)
  );

  // bytes for a ladder index
  function automatic logic [matrix_trap_pkg::BYTES_W-1:0] idx_bytes(
    input logic [matrix_trap_pkg::KIDX_W-1:0] k
  );
    return matrix_trap_pkg::BYTES_W'(matrix_trap_pkg::LEN_UNIT_BYTES) << k;
  endfunction

  // pick the level's own resolved length, no register in between
  always_comb
  begin
    case (lvl)
      matrix_trap_pkg::LVL_MONITOR:    k_cur = lif.k3;
      matrix_trap_pkg::LVL_HYPERVISOR: k_cur = lif.k2;
      default:                         k_cur = lif.k1;  // user shares the kernel length
    endcase
  end

  assign effective_stream_length = idx_bytes(k_cur);
  // stream mode overrides the ordinary length
  assign effective_vector_length = stream_mode_bit ? effective_stream_length : nonstream_vector_bytes;
  // policy for newly visible bits on growth, fixed per build
  assign grow_fill_zero = GROW_ZERO_FILL;

  // class grouping
  logic is_matrix;   // any instruction the access controls can trap
  logic is_table;    // lookup_table_register users
  assign is_matrix = (kind != matrix_trap_pkg::KIND_NONE);
  assign is_table  = (kind == matrix_trap_pkg::KIND_TABLE);

  // level-1 field: which levels it lets through
  logic l1_blocks;   // level-1 control traps this level
  always_comb
  begin
    l1_blocks = 1'b0;
    if (lvl == matrix_trap_pkg::LVL_USER || lvl == matrix_trap_pkg::LVL_KERNEL)
    begin
      if (level1_matrix_access_enable == matrix_trap_pkg::MATRIX_ACCESS_ENABLE_NO_TRAP)
        l1_blocks = 1'b0;
      else if (level1_matrix_access_enable == matrix_trap_pkg::MATRIX_ACCESS_ENABLE_TRAP_USER_ONLY)
        l1_blocks = (lvl == matrix_trap_pkg::LVL_USER);
      else
        l1_blocks = 1'b1;
    end
  end

  // lower levels reach hypervisor checks only where it exists
  logic below_mon;   // not at monitor level
  logic l1_scope;    // user or kernel
  logic l1_target_hyp; // level-1 trap is routed to hypervisor
  assign below_mon     = (lvl != matrix_trap_pkg::LVL_MONITOR);
  assign l1_scope      = (lvl == matrix_trap_pkg::LVL_USER) || (lvl == matrix_trap_pkg::LVL_KERNEL);
  assign l1_target_hyp = hyp_present && kernel_route_to_hyp && (lvl == matrix_trap_pkg::LVL_USER);

  // trap decision, highest priority first
  logic                                 trap_hit;  // this instruction traps
  matrix_trap_pkg::level_e              tgt;       // level that takes it
  logic [matrix_trap_pkg::ISS_W-1:0]    iss;       // syndrome code
  always_comb
  begin
    trap_hit = 1'b0;
    tgt      = matrix_trap_pkg::LVL_KERNEL;
    iss      = matrix_trap_pkg::ISS_CONFIG;
    if (!is_matrix)
      trap_hit = 1'b0;
    // level-1 enable checked first
    else if (l1_blocks)
    begin
      trap_hit = 1'b1;
      tgt      = l1_target_hyp ? matrix_trap_pkg::LVL_HYPERVISOR : matrix_trap_pkg::LVL_KERNEL;
    end
    // level-2 enable, then its trap bit
    else if (hyp_present && below_mon && !level2_matrix_access_enable)
    begin
      trap_hit = 1'b1;
      tgt      = matrix_trap_pkg::LVL_HYPERVISOR;
    end
    else if (hyp_present && below_mon && level2_matrix_trap_bit)
    begin
      trap_hit = 1'b1;
      tgt      = matrix_trap_pkg::LVL_HYPERVISOR;
    end
    // level-3 enable covers every level
    else if (!matrix_enable_level3)
    begin
      trap_hit = 1'b1;
      tgt      = matrix_trap_pkg::LVL_MONITOR;
    end
    // vector registers need stream mode; array ops are exempt
    else if (kind != matrix_trap_pkg::KIND_ARRAY_VEC && instr_uses_vector_regs && !stream_mode_bit)
    begin
      trap_hit = 1'b1;
      tgt      = (lvl == matrix_trap_pkg::LVL_USER) ? matrix_trap_pkg::LVL_KERNEL : lvl;
      iss      = matrix_trap_pkg::ISS_NOT_STREAM;
    end
    // array storage off blocks array and table users
    else if ((instr_uses_array || is_table || kind == matrix_trap_pkg::KIND_ARRAY_VEC) && !array_storage_enable_bit)
    begin
      trap_hit = 1'b1;
      tgt      = (lvl == matrix_trap_pkg::LVL_USER) ? matrix_trap_pkg::LVL_KERNEL : lvl;
      iss      = matrix_trap_pkg::ISS_ARRAY_OFF;
    end
    // table enables, level 1 then 2 then 3
    else if (is_table && l1_scope && !lookup_table_enable[matrix_trap_pkg::TBL_EN_L1])
    begin
      trap_hit = 1'b1;
      tgt      = l1_target_hyp ? matrix_trap_pkg::LVL_HYPERVISOR : matrix_trap_pkg::LVL_KERNEL;
      iss      = matrix_trap_pkg::ISS_TABLE_OFF;
    end
    else if (is_table && hyp_present && below_mon && !lookup_table_enable[matrix_trap_pkg::TBL_EN_L2])
    begin
      trap_hit = 1'b1;
      tgt      = matrix_trap_pkg::LVL_HYPERVISOR;
      iss      = matrix_trap_pkg::ISS_TABLE_OFF;
    end
    else if (is_table && !lookup_table_enable[matrix_trap_pkg::TBL_EN_L3])
    begin
      trap_hit = 1'b1;
      tgt      = matrix_trap_pkg::LVL_MONITOR;
      iss      = matrix_trap_pkg::ISS_TABLE_OFF;
    end
  end

  // trap report, one-cycle pulse with held payload
  logic                              trap_valid_reg;
  matrix_trap_pkg::level_e           trap_target_reg;
  logic [matrix_trap_pkg::EC_W-1:0]  ec_reg;
  logic [matrix_trap_pkg::ISS_W-1:0] iss_reg;
  matrix_trap_pkg::trace_type_e      trace_reg;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      trap_valid_reg  <= 1'b0;
      trap_target_reg <= matrix_trap_pkg::LVL_USER;
      ec_reg          <= '0;
      iss_reg         <= '0;
      trace_reg       <= matrix_trap_pkg::TRACE_NONE;
    end
    else if (clk_en)
    begin
      trap_valid_reg <= instr_valid && trap_hit;
      if (instr_valid && trap_hit)
      begin
        trap_target_reg <= tgt;
        ec_reg          <= matrix_trap_pkg::EC_MATRIX;
        iss_reg         <= iss;
        trace_reg       <= matrix_trap_pkg::TRACE_TRAP;
      end
    end
  end

  // accepted instruction results
  logic                               accept_reg;
  logic [matrix_trap_pkg::BYTES_W-1:0] read_len_reg;
  logic [matrix_trap_pkg::BYTES_W-1:0] array_len_reg;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      accept_reg    <= 1'b0;
      read_len_reg  <= '0;
      array_len_reg <= '0;
    end
    else if (clk_en)
    begin
      accept_reg <= instr_valid && !trap_hit;
      // read-length returns bytes of the resolved length
      if (instr_valid && !trap_hit && kind == matrix_trap_pkg::KIND_READ_LEN)
        read_len_reg <= effective_stream_length;
      // array transfers size by stream length in either mode
      if (instr_valid && !trap_hit && kind == matrix_trap_pkg::KIND_ARRAY_VEC)
        array_len_reg <= effective_stream_length;
    end
  end

  // growth watch: only flags, never wipes storage, so a raise and
  // restore leaves contents intact
  logic [matrix_trap_pkg::KIDX_W-1:0] k_prev_reg;  // index seen last cycle
  logic                               sm_prev_reg; // stream mode last cycle
  logic                               grew_reg;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      k_prev_reg  <= '0;
      sm_prev_reg <= 1'b0;
      grew_reg    <= 1'b0;
    end
    else if (clk_en)
    begin
      k_prev_reg  <= k_cur;
      sm_prev_reg <= stream_mode_bit;
      // length increase inside stream mode, from write or level change
      grew_reg    <= sm_prev_reg && stream_mode_bit && (k_cur > k_prev_reg);
    end
  end

  assign trap_valid            = trap_valid_reg;
  assign trap_target_level     = trap_target_reg;
  assign exception_class_field = ec_reg;
  assign trap_syndrome         = iss_reg;
  assign trace_exception_type  = trace_reg;
  assign instr_accept          = accept_reg;
  assign read_len_bytes        = read_len_reg;
  assign array_access_bytes    = array_len_reg;
  assign stream_len_grew       = grew_reg;

  // an instruction taken on an enabled edge
  sequence issue_s;
    clk_en && instr_valid;
  endsequence

  // the level-3 table bit is off
  sequence table_l3_off_s;
    (kind == matrix_trap_pkg::KIND_TABLE) && !lookup_table_enable[matrix_trap_pkg::TBL_EN_L3];
  endsequence

  // every taken instruction ends in exactly one answer
  issue_answer_a: assert property (@(posedge mclk) disable iff (rst)
    issue_s |=> (trap_valid ^ instr_accept))
    else $error("instruction without single answer");

  // kernel-target traps only come from user or kernel
  kernel_target_a: assert property (@(posedge mclk) disable iff (rst)
    trap_hit && tgt == matrix_trap_pkg::LVL_KERNEL |-> l1_scope)
    else $error("kernel-target trap from wrong level");

  // level-2 trap bit traps below monitor when the hypervisor level exists
  hyp_trap_a: assert property (@(posedge mclk) disable iff (rst)
    issue_s ##0 (is_matrix && hyp_present && below_mon && level2_matrix_trap_bit) |=> trap_valid)
    else $error("level-2 trap bit ignored");

  // level-3 disable traps everything matrix-related
  mon_trap_a: assert property (@(posedge mclk) disable iff (rst)
    issue_s ##0 (is_matrix && !matrix_enable_level3) |=> trap_valid)
    else $error("level-3 disable ignored");

  // table access with level-3 bit off traps
  table_trap_a: assert property (@(posedge mclk) disable iff (rst)
    issue_s ##0 table_l3_off_s |=> trap_valid)
    else $error("table access not trapped");

  // syndrome class and trace type on every trap
  class_code_a: assert property (@(posedge mclk) disable iff (rst)
    trap_valid |-> exception_class_field == matrix_trap_pkg::EC_MATRIX)
    else $error("wrong exception class");

  trace_type_a: assert property (@(posedge mclk) disable iff (rst)
    trap_valid |-> trace_exception_type == matrix_trap_pkg::TRACE_TRAP)
    else $error("trap not traced as trap type");

  // stream mode ties the two lengths
  vector_tie_a: assert property (@(posedge mclk) disable iff (rst)
    stream_mode_bit |-> effective_vector_length == effective_stream_length)
    else $error("vector length differs in stream mode");

  // current level's resolved size is implemented, and resolved sizes nest by privilege
  size_nest_a: assert property (@(posedge mclk) disable iff (rst)
    SUPPORTED_SIZES[k_cur] && lif.k2 <= lif.k3 && lif.k1 <= (hyp_present ? lif.k2 : lif.k3))
    else $error("resolved length out of order");

  // read-length result is the length at issue time
  read_len_a: assert property (@(posedge mclk) disable iff (rst)
    issue_s ##0 (kind == matrix_trap_pkg::KIND_READ_LEN && !trap_hit)
      |=> read_len_bytes == $past(effective_stream_length))
    else $error("read length mismatch");

endmodule
`default_nettype wire

// [core/matrix_trap_pkg.sv]
`default_nettype none
package matrix_trap_pkg;
  // widths of the fields that cross the block boundary
  localparam int LEN_W     = 9;            // requested length field, bits [8:0]
  localparam int UNITS_W   = 10;           // request in 16-byte units, LEN + 1
  localparam int EC_W      = 6;            // exception class field width
  localparam int ISS_W     = 25;           // syndrome code width
  localparam int BYTES_W   = 16;           // byte lengths reported outward
  localparam int NUM_SIZES = 5;            // power-of-two sizes, 1..16 units
  localparam int KIDX_W    = 3;            // index into the size ladder

  // length encoding
  localparam logic [UNITS_W-1:0] LEN_UNIT_BYTES = 10'h010;  // one length unit is 16 bytes
  localparam logic [UNITS_W-1:0] UNITS_ONE      = 10'h001;  // LEN + 1 gives the unit count
  localparam logic [LEN_W-1:0]   LEN_RESET      = 9'h1ff;   // reset request: largest encodable

  // default set of implemented sizes, bit i means 16 << i bytes
  localparam logic [NUM_SIZES-1:0] SUPPORTED_DEFAULT = 5'h1f;

  // syndrome encodings
  localparam logic [EC_W-1:0]  EC_MATRIX      = 6'h1d;      // 0b011101
  localparam logic [ISS_W-1:0] ISS_CONFIG     = 25'h0000000;
  localparam logic [ISS_W-1:0] ISS_NOT_STREAM = 25'h0000002;
  localparam logic [ISS_W-1:0] ISS_ARRAY_OFF  = 25'h0000003;
  localparam logic [ISS_W-1:0] ISS_TABLE_OFF  = 25'h0000004;

  // level-1 matrix_access_enable field codes
  localparam logic [1:0] MATRIX_ACCESS_ENABLE_TRAP_USER_ONLY = 2'h1;
  localparam logic [1:0] MATRIX_ACCESS_ENABLE_NO_TRAP        = 2'h3;

  // lookup_table_enable bit positions, one per level
  localparam int TBL_EN_L1 = 0;
  localparam int TBL_EN_L2 = 1;
  localparam int TBL_EN_L3 = 2;

  // privilege levels
  typedef enum logic [1:0] {
    LVL_USER       = 2'b00,
    LVL_KERNEL     = 2'b01,
    LVL_HYPERVISOR = 2'b10,
    LVL_MONITOR    = 2'b11
  } level_e;

  // instruction classes presented by decode
  typedef enum logic [2:0] {
    KIND_NONE      = 3'b000,  // not a matrix-related instruction
    KIND_DATA_PROC = 3'b001,  // matrix data processing
    KIND_MODE_CHG  = 3'b010,  // enter/exit stream mode
    KIND_SYSREG    = 3'b011,  // read/write of mode or length control
    KIND_TABLE     = 3'b100,  // lookup_table_register access
    KIND_ARRAY_VEC = 3'b101,  // unpredicated array load/store/zero
    KIND_READ_LEN  = 3'b110   // read_stream_length_instr
  } instr_kind_e;

  // trace and branch-record exception type
  typedef enum logic [1:0] {
    TRACE_NONE = 2'b00,
    TRACE_TRAP = 2'b01
  } trace_type_e;
endpackage
`default_nettype wire

// [core/len_if.sv]
`default_nettype none
// carries the per-level length requests to the resolver and its answers back
interface len_if;
  logic [matrix_trap_pkg::LEN_W-1:0]     req1;       // kernel level request
  logic [matrix_trap_pkg::LEN_W-1:0]     req2;       // hypervisor level request
  logic [matrix_trap_pkg::LEN_W-1:0]     req3;       // monitor level request
  logic                                  hyp_present; // hypervisor level exists here
  logic [matrix_trap_pkg::NUM_SIZES-1:0] supported;  // implemented size set
  logic [matrix_trap_pkg::KIDX_W-1:0]    k1;         // resolved index, kernel and user
  logic [matrix_trap_pkg::KIDX_W-1:0]    k2;         // resolved index, hypervisor
  logic [matrix_trap_pkg::KIDX_W-1:0]    k3;         // resolved index, monitor
  modport resolver (input req1, req2, req3, hyp_present, supported, output k1, k2, k3);
  modport user     (output req1, req2, req3, hyp_present, supported, input k1, k2, k3);
endinterface
`default_nettype wire

// [core/stream_len_resolver.sv]
`default_nettype none
// purely combinational, so a new request applies to the very next instruction
module stream_len_resolver (
  len_if.resolver lif
);
  // highest implemented size index
  function automatic logic [matrix_trap_pkg::KIDX_W-1:0] top_index(
    input logic [matrix_trap_pkg::NUM_SIZES-1:0] sup
  );
    logic [matrix_trap_pkg::KIDX_W-1:0] t;
    t = '0;
    for (int i = 0; i < matrix_trap_pkg::NUM_SIZES; i++)
    begin
      if (sup[i])
        t = matrix_trap_pkg::KIDX_W'(i);
    end
    return t;
  endfunction

  // unit count of ladder step i
  function automatic logic [matrix_trap_pkg::UNITS_W-1:0] unit_count(input int i);
    return matrix_trap_pkg::UNITS_ONE << i;
  endfunction

  // resolve one request against a ceiling index
  function automatic logic [matrix_trap_pkg::KIDX_W-1:0] resolve(
    input logic [matrix_trap_pkg::LEN_W-1:0]     req,
    input logic [matrix_trap_pkg::KIDX_W-1:0]    cap,
    input logic [matrix_trap_pkg::NUM_SIZES-1:0] sup
  );
    logic [matrix_trap_pkg::UNITS_W-1:0] units;
    logic [matrix_trap_pkg::KIDX_W-1:0]  best;
    logic                                seen;
    units = {1'b0, req} + matrix_trap_pkg::UNITS_ONE;
    best  = '0;
    seen  = 1'b0;
    // start from the minimum, so a short request lands there
    for (int i = matrix_trap_pkg::NUM_SIZES - 1; i >= 0; i--)
    begin
      if (sup[i])
      begin
        best = matrix_trap_pkg::KIDX_W'(i);
        seen = 1'b1;
      end
    end
    // climb to the largest supported size not above request or ceiling
    for (int i = 0; i < matrix_trap_pkg::NUM_SIZES; i++)
    begin
      if (seen && sup[i] && (unit_count(i) <= units) && (matrix_trap_pkg::KIDX_W'(i) <= cap))
        best = matrix_trap_pkg::KIDX_W'(i);
    end
    return best;
  endfunction

  // monitor level is highest: ceiling is the largest size
  assign lif.k3 = resolve(lif.req3, top_index(lif.supported), lif.supported);
  // lower levels are capped by the next more privileged level
  assign lif.k2 = resolve(lif.req2, lif.k3, lif.supported);
  assign lif.k1 = resolve(lif.req1, lif.hyp_present ? lif.k2 : lif.k3, lif.supported);
endmodule
`default_nettype wire

// [core/dummy_end_marker_unused.sv]
`default_nettype none
`default_nettype wire

// [test/decode_model.sv]
`default_nettype none
// decode side: one instruction held for one cycle, changed on the falling edge
module decode_model (
  input  wire logic       mclk,
  output logic            instr_valid,
  output logic [2:0]      instr_kind,
  output logic            instr_uses_vector_regs,
  output logic            instr_uses_array
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle until asked; kind held on a non-zero pattern so stale values never pass
  initial
  begin
    instr_valid = 1'b0;
    instr_kind = 3'h7;
    instr_uses_vector_regs = 1'b0;
    instr_uses_array = 1'b0;
  end
  // presents one instruction, then drops valid; back to back calls stay legal
  task automatic issue(input logic [2:0] k, input logic v);
    @(negedge mclk);
    instr_valid = 1'b1;
    instr_kind = k;
    instr_uses_vector_regs = v;
    @(negedge mclk);
    instr_valid = 1'b0;
    instr_kind = ~k;
  endtask
endmodule
`default_nettype wire

// [test/test_matrix_trap_and_stream_len.sv]
`default_nettype none
module test_matrix_trap_and_stream_len;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst = 1'b1, clk_en = 1'b1, hyp = 1'b1, route = 1'b0;
  logic [1:0] lvl = 2'h1, l1en = 2'h3;
  logic l2en = 1'b1, l2trap = 1'b0, l3en = 1'b1, sm = 1'b1, za = 1'b1;
  logic [2:0] lte = 3'h7;
  logic [8:0] r1 = 9'h1ff, r2 = 9'h1ff, r3 = 9'h1ff;
  logic [15:0] nsv = 16'h0020;
  logic iv, iu, ia, tv, acc, grew, gz;
  logic [2:0] ik;
  logic [1:0] tgt, trc;
  logic [5:0] ec;
  logic [24:0] syn;
  logic [15:0] rlb, aab, esl, evl;
  int fail_count = 0, n_compared = 0, cyc = 0;
  decode_model dm_inst (.mclk(mclk), .instr_valid(iv), .instr_kind(ik), .instr_uses_vector_regs(iu),
    .instr_uses_array(ia));
  matrix_trap_and_stream_len matrix_trap_and_stream_len_inst (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .cur_level(lvl), .hyp_present(hyp), .kernel_route_to_hyp(route), .level1_matrix_access_enable(l1en),
    .level2_matrix_access_enable(l2en), .level2_matrix_trap_bit(l2trap), .matrix_enable_level3(l3en),
    .lookup_table_enable(lte), .stream_length_control_l1(r1), .stream_length_control_l2(r2),
    .stream_length_control_l3(r3), .stream_mode_bit(sm), .array_storage_enable_bit(za),
    .nonstream_vector_bytes(nsv), .instr_valid(iv), .instr_kind(ik), .instr_uses_vector_regs(iu),
    .instr_uses_array(ia), .trap_valid(tv), .trap_target_level(tgt), .exception_class_field(ec),
    .trap_syndrome(syn), .trace_exception_type(trc), .instr_accept(acc), .read_len_bytes(rlb),
    .array_access_bytes(aab), .effective_stream_length(esl), .effective_vector_length(evl),
    .stream_len_grew(grew), .grow_fill_zero(gz));
  // 40 ns period
  always #20 mclk = ~mclk;
  // hang guard, far above the roughly 35 cycles the tests need
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      close_out();
    end
  end
  // one compare for every kind of value, widened to the syndrome width
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // issues one instruction and expects a trap with the given target and code
  task automatic trap_chk(input logic [2:0] k, input logic [1:0] t, input logic [24:0] s);
    dm_inst.issue(k, 1'b0);
    chk(tv, 1'b1);
    chk(acc, 1'b0);
    chk(tgt, t);
    chk(ec, matrix_trap_pkg::EC_MATRIX);
    chk(trc, matrix_trap_pkg::TRACE_TRAP);
    chk(syn, s);
  endtask
  // each level's control and the level-3 table enable, checked from lowest priority up
  task automatic t_traps;
    lte = 3'b011;
    trap_chk(matrix_trap_pkg::KIND_TABLE, 2'h3, matrix_trap_pkg::ISS_TABLE_OFF);
    lte = 3'h7;
    l3en = 1'b0;
    lvl = 2'h0;
    trap_chk(matrix_trap_pkg::KIND_DATA_PROC, 2'h3, matrix_trap_pkg::ISS_CONFIG);
    l2trap = 1'b1;
    lvl = 2'h2;
    trap_chk(matrix_trap_pkg::KIND_SYSREG, 2'h2, matrix_trap_pkg::ISS_CONFIG);
    l2trap = 1'b0;
    l1en = 2'h0;
    lvl = 2'h1;
    trap_chk(matrix_trap_pkg::KIND_MODE_CHG, 2'h1, matrix_trap_pkg::ISS_CONFIG);
    l1en = 2'h3;
    l3en = 1'b1;
    $display("traps done");
  endtask
  // length ladder: floor, cap, round down, and the lengths the instructions see
  task automatic t_len;
    lvl = 2'h3;
    @(negedge mclk);
    chk(esl, 16'h0100);
    r3 = 9'h002;
    @(negedge mclk);
    chk(esl, 16'h0020);
    r3 = 9'h003;
    lvl = 2'h1;
    hyp = 1'b0;
    @(negedge mclk);
    chk(esl, 16'h0040);
    chk(evl, 16'h0040);
    r1 = 9'h000;
    @(negedge mclk);
    chk(esl, 16'h0010);
    r1 = 9'h1ff;
    dm_inst.issue(matrix_trap_pkg::KIND_READ_LEN, 1'b0);
    chk(acc, 1'b1);
    chk(rlb, 16'h0040);
    sm = 1'b0;
    dm_inst.issue(matrix_trap_pkg::KIND_ARRAY_VEC, 1'b0);
    chk(acc, 1'b1);
    chk(aab, 16'h0040);
    chk(evl, nsv);
    $display("lengths done");
  endtask
  // growth inside stream mode: explicit write, restore, then a climb of level
  task automatic t_grow;
    sm = 1'b1;
    r3 = 9'h003;
    r1 = 9'h000;
    @(negedge mclk);
    r1 = 9'h1ff;
    @(negedge mclk);
    chk(grew, 1'b1);
    chk(esl, 16'h0040);
    chk(gz, 1'b0);
    r1 = 9'h000;
    @(negedge mclk);
    chk(grew, 1'b0);
    chk(esl, 16'h0010);
    lvl = 2'h3;
    @(negedge mclk);
    chk(grew, 1'b1);
    @(negedge mclk);
    chk(grew, 1'b0);
    $display("growth done");
  endtask
  // single place where the run ends
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_traps();
    t_len();
    t_grow();
    close_out();
  end
endmodule
`default_nettype wire
